// File: logic/uic_top.sv
// Serial port core: interrupt identification, line format, modem control
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Receive queue: parameterised FIFO with valid/ready on both sides
module uic_fifo #(
   parameter int W = 11,
   parameter int D = 32
) (
   input wire logic clk_in, // Clock
   input wire logic resetn_in, // Async reset, low
   input wire logic clr_in, // Flush
   input wire logic in_valid_in, // Write request
   output logic in_ready_out, // Space left
   input wire logic [W-1:0] in_data_in, // Write word
   output logic out_valid_out, // Word present
   input wire logic out_ready_in, // Read request
   output logic [W-1:0] out_data_out, // Head word
   output logic [$clog2(D):0] count_out // Fill level
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem_r [D];
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic push, pop;
   // Handshake terms
   assign in_ready_out = (cnt_r != (AW+1)'(D));
   assign out_valid_out = (cnt_r != '0);
   assign out_data_out = mem_r[rp_r];
   assign count_out = cnt_r;
   assign push = in_valid_in & in_ready_out;
   assign pop = out_valid_out & out_ready_in;
   // Pointer update; depth must be a power of two for natural wrap
   always_comb begin
      wp_nxt = wp_r + AW'(push);
      rp_nxt = rp_r + AW'(pop);
      cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      if (clr_in) begin
         wp_nxt = '0;
         rp_nxt = '0;
         cnt_nxt = '0;
      end
   end
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end
   // Storage has no reset; contents are guarded by the count
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_r[wp_r] <= in_data_in;
      end
   end
endmodule : uic_fifo

// ==========================================================
module uic_top (
   input wire logic clk_in, // 20 MHz clock
   input wire logic resetn_in, // Async reset, low
   input wire uic_pkg::uic_hreq_type host_in, // Host register access
   output logic [7:0] rdata_out, // Read data, next cycle
   output logic txd_out, // Serial out
   input wire logic rxd_in, // Serial in
   input wire logic cts_n_in, // Clear to send, low
   input wire logic dsr_n_in, // Data set ready, low
   input wire logic ri_n_in, // Ring, low
   input wire logic dcd_n_in, // Carrier detect, low
   output logic dtr_n_out, // Terminal ready, low
   output logic rts_n_out, // Request to send, low
   output logic irq_out // Interrupt, high
);
   import uic_pkg::*;
   typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} uic_tx_type;
   typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_WAIT} uic_rx_type;
   logic [3:0] ier_r, ier_nxt, iir_r, iir_nxt, prio, dlt_r, dlt_nxt, mp_r, mi, chg;
   logic [7:0] lcr_r, lcr_nxt, dll_r, dll_nxt, dlm_r, dlm_nxt, scr_r, scr_nxt;
   logic [7:0] thr_r, thr_nxt, rd_mux, rdata_r, rdata_nxt, dmask, lsr;
   logic [4:0] mcr_r, mcr_nxt, tph_r, tph_nxt, rph_r, rph_nxt, tlim, rlim, bph_r, bph_nxt;
   logic [1:0] trg_r, trg_nxt;
   logic fen_r, fen_nxt, rclr, thr_wr, thr_full_r, thr_full_nxt, load, dls, wd_ok;
   logic [15:0] div_cnt_r, div_cnt_nxt;
   logic tick_r, tick_nxt, txi_r, txi_nxt, tpar_r, tpar_nxt, txd_r, txd_nxt;
   uic_tx_type tst_r, tst_nxt;
   uic_rx_type rst_r, rst_nxt;
   logic [2:0] tbit_r, tbit_nxt, rbit_r, rbit_nxt, last_idx;
   logic [7:0] tsh_r, tsh_nxt, rsh_r, rsh_nxt;
   logic rpe_r, rpe_nxt, rx_s, rx_push, stop_ok, rx_fe;
   logic hold, rd_iir, rd_lsr, rd_msr, rd_rbr;
   logic oe_r, oe_nxt, pe_r, pe_nxt, fe_r, fe_nxt, bi_r, bi_nxt, thip_r, thip_nxt;
   logic tmo_r, tmo_nxt, irq_r, irq_nxt, dtr_n_r, dtr_n_nxt, rts_n_r, rts_n_nxt;
   logic rls_p, rda_p, tmo_p, thr_p, ms_p, rda_lvl, q_in_valid, q_ready, q_valid, acc;
   logic [5:0] q_cnt, tcnt_r, tcnt_nxt, tmo_lim, trg_lvl;
   uic_rxch_type rx_ch, q_head;

   // ==========================================================
   // Host access decode
   assign dls = lcr_r[L_DLS];
   assign hold = host_in.rd & (host_in.addr == A_IIR);
   assign rd_iir = hold;
   assign rd_lsr = host_in.rd & (host_in.addr == A_LSR);
   assign rd_msr = host_in.rd & (host_in.addr == A_MSR);
   assign rd_rbr = host_in.rd & (host_in.addr == A_DATA) & ~dls;
   assign wd_ok = host_in.wdata[F_EN];

   // Register writes; FIFO control only takes its other bits with enable set
   always_comb begin
      ier_nxt = ier_r;
      lcr_nxt = lcr_r;
      mcr_nxt = mcr_r;
      dll_nxt = dll_r;
      dlm_nxt = dlm_r;
      scr_nxt = scr_r;
      thr_nxt = thr_r;
      fen_nxt = fen_r;
      trg_nxt = trg_r;
      rclr = 1'b0;
      thr_wr = 1'b0;
      if (host_in.wr) begin
         case (host_in.addr)
            A_DATA: begin
               if (dls) dll_nxt = host_in.wdata;
               else begin
                  thr_nxt = host_in.wdata;
                  thr_wr = 1'b1;
               end
            end
            A_IER: begin
               if (dls) dlm_nxt = host_in.wdata;
               else ier_nxt = host_in.wdata[3:0];
            end
            A_IIR: begin
               fen_nxt = wd_ok;
               rclr = ~wd_ok | host_in.wdata[F_RCLR] | ~fen_r;
               if (wd_ok) trg_nxt = host_in.wdata[F_TRG +: 2];
            end
            A_LCR: lcr_nxt = host_in.wdata;
            A_MCR: mcr_nxt = host_in.wdata[4:0];
            A_SCR: scr_nxt = host_in.wdata;
            default: ;
         endcase
      end
   end

   // Read mux; answer lands one cycle after the read strobe
   always_comb begin
      case (host_in.addr)
         A_DATA: rd_mux = dls ? dll_r : q_head.data;
         A_IER: rd_mux = dls ? dlm_r : {4'h0, ier_r};
         A_IIR: rd_mux = {fen_r, fen_r, 2'b00, iir_r};
         A_LCR: rd_mux = lcr_r;
         A_MCR: rd_mux = {3'h0, mcr_r};
         A_LSR: rd_mux = lsr;
         A_MSR: rd_mux = {mp_r, dlt_r};
         default: rd_mux = scr_r;
      endcase
      rdata_nxt = host_in.rd ? rd_mux : rdata_r;
   end

   // ==========================================================
   // Baud tick: one pulse per divisor count, sixteen per bit
   always_comb begin
      tick_nxt = (div_cnt_r <= DIV_ONE);
      div_cnt_nxt = tick_nxt ? {dlm_r, dll_r} : div_cnt_r - DIV_ONE;
      bph_nxt = tick_r ? ((bph_r == PH_BIT) ? 5'h00 : bph_r + 5'h01) : bph_r;
   end

   // ==========================================================
   // Transmitter; character is masked to the selected length
   assign last_idx = 3'(lcr_r[1:0]) + LEN_BASE;
   assign dmask = 8'hFF >> (3'h7 - last_idx);
   always_comb begin
      tst_nxt = tst_r;
      tbit_nxt = tbit_r;
      tsh_nxt = tsh_r;
      tpar_nxt = tpar_r;
      load = 1'b0;
      txi_nxt = 1'b1;
      if (!lcr_r[L_STB]) tlim = PH_BIT;
      else tlim = (lcr_r[1:0] == 2'b00) ? PH_STOP15 : PH_STOP2;
      if (tst_r != TX_STOP) tlim = PH_BIT;
      tph_nxt = (tick_r && tst_r != TX_IDLE) ? ((tph_r == tlim) ? 5'h00 : tph_r + 5'h01) : tph_r;
      case (tst_r)
         TX_IDLE: begin
            tph_nxt = 5'h00;
            if (thr_full_r) begin
               load = 1'b1;
               tsh_nxt = thr_r & dmask;
               // Stick forces inverse of even select, else odd/even sum
               tpar_nxt = lcr_r[L_STK] ? ~lcr_r[L_EPS] : ^(thr_r & dmask) ^ ~lcr_r[L_EPS];
               tst_nxt = TX_START;
            end
         end
         TX_START: begin
            txi_nxt = 1'b0;
            tbit_nxt = 3'h0;
            if (tick_r && tph_r == tlim) tst_nxt = TX_DATA;
         end
         TX_DATA: begin
            txi_nxt = tsh_r[tbit_r];
            if (tick_r && tph_r == tlim) begin
               tbit_nxt = tbit_r + 3'h1;
               if (tbit_r == last_idx) tst_nxt = lcr_r[L_PEN] ? TX_PAR : TX_STOP;
            end
         end
         TX_PAR: begin
            txi_nxt = tpar_r;
            if (tick_r && tph_r == tlim) tst_nxt = TX_STOP;
         end
         TX_STOP: begin
            if (tick_r && tph_r == tlim) tst_nxt = TX_IDLE;
         end
         default: tst_nxt = TX_IDLE;
      endcase
      // A write landing with the load keeps the holding register full
      thr_full_nxt = thr_wr | (thr_full_r & ~load);
      // Loopback marks the pin; break forces space whatever is sent
      txd_nxt = mcr_r[M_LOOP] ? 1'b1 : (lcr_r[L_BRK] ? 1'b0 : txi_r);
   end

   // ==========================================================
   // Receiver; start is rechecked at mid-bit to reject glitches
   assign rx_s = mcr_r[M_LOOP] ? txi_r : rxd_in;
   always_comb begin
      rst_nxt = rst_r;
      rbit_nxt = rbit_r;
      rsh_nxt = rsh_r;
      rpe_nxt = rpe_r;
      rx_push = 1'b0;
      rlim = (rst_r == RX_START) ? PH_HALF : PH_BIT;
      stop_ok = tick_r & (rph_r == rlim);
      rph_nxt = tick_r ? (stop_ok ? 5'h00 : rph_r + 5'h01) : rph_r;
      rx_fe = ~rx_s;
      case (rst_r)
         RX_IDLE: begin
            rph_nxt = 5'h00;
            if (!rx_s) rst_nxt = RX_START;
         end
         RX_START: begin
            rbit_nxt = 3'h0;
            rsh_nxt = 8'h00;
            if (stop_ok) rst_nxt = rx_s ? RX_IDLE : RX_DATA;
         end
         RX_DATA: begin
            if (stop_ok) begin
               rsh_nxt[rbit_r] = rx_s;
               rbit_nxt = rbit_r + 3'h1;
               if (rbit_r == last_idx) rst_nxt = lcr_r[L_PEN] ? RX_PAR : RX_STOP;
               rpe_nxt = 1'b0;
            end
         end
         RX_PAR: begin
            if (stop_ok) begin
               rpe_nxt = rx_s != (lcr_r[L_STK] ? ~lcr_r[L_EPS] : ^rsh_r ^ ~lcr_r[L_EPS]);
               rst_nxt = RX_STOP;
            end
         end
         RX_STOP: begin
            // Only the first stop is sampled; later stops look like idle
            if (stop_ok) begin
               rx_push = 1'b1;
               rst_nxt = rx_s ? RX_IDLE : RX_WAIT;
            end
         end
         RX_WAIT: begin
            // Break or framing fault: wait for mark so one char is queued
            rph_nxt = 5'h00;
            if (rx_s) rst_nxt = RX_IDLE;
         end
         default: rst_nxt = RX_IDLE;
      endcase
      rx_ch = '{bi: rx_fe & (rsh_r == 8'h00), fe: rx_fe, pe: rpe_r, data: rsh_r};
   end

   // Outside FIFO mode the queue acts as a single holding register
   assign q_in_valid = rx_push & (fen_r | ~q_valid);
   assign acc = q_in_valid & q_ready;

   uic_fifo #(.W($bits(uic_rxch_type)), .D(RXQ_DEPTH)) u_rxq (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .clr_in(rclr),
      .in_valid_in(q_in_valid),
      .in_ready_out(q_ready),
      .in_data_in(rx_ch),
      .out_valid_out(q_valid),
      .out_ready_in(rd_rbr),
      .out_data_out(q_head),
      .count_out(q_cnt)
   );

   // ==========================================================
   // Status, sources and identification; set beats clear, except that a data read clears the timeout
   always_comb begin
      case (trg_r)
         2'b00: trg_lvl = TRG_1;
         2'b01: trg_lvl = TRG_4;
         2'b10: trg_lvl = TRG_8;
         default: trg_lvl = TRG_14;
      endcase
      rda_lvl = fen_r ? (q_cnt >= trg_lvl) : q_valid;
      oe_nxt = (rx_push & ~acc) | (oe_r & ~rd_lsr);
      pe_nxt = (acc & rx_ch.pe) | (pe_r & ~rd_lsr);
      fe_nxt = (acc & rx_ch.fe) | (fe_r & ~rd_lsr);
      bi_nxt = (acc & rx_ch.bi) | (bi_r & ~rd_lsr);
      lsr = {fen_r & (pe_r | fe_r | bi_r), ~thr_full_r & (tst_r == TX_IDLE), ~thr_full_r,
             bi_r, fe_r, pe_r, oe_r, q_valid};
      // Four character times counted in bit times: start+data+parity+stops, times four
      tmo_lim = {4'(lcr_r[1:0]) + CH_BASE + 4'(lcr_r[L_PEN]) + 4'(lcr_r[L_STB]), 2'b00};
      if (!q_valid || acc || rd_rbr) tcnt_nxt = 6'h00;
      else if (tick_r && bph_r == PH_BIT && tcnt_r != tmo_lim) tcnt_nxt = tcnt_r + 6'h01;
      else tcnt_nxt = tcnt_r;
      tmo_nxt = fen_r & q_valid & ~rd_rbr & ((tcnt_r == tmo_lim) | tmo_r);
      thip_nxt = load | (~ier_r[E_THR] & ier_nxt[E_THR] & ~thr_full_r)
                 | (thip_r & ~thr_wr & ~(rd_iir & iir_r == ID_THR));
      mi = mcr_r[M_LOOP] ? {mcr_r[M_OUT2], mcr_r[2], mcr_r[M_DTR], mcr_r[M_RTS]}
                         : ~{dcd_n_in, ri_n_in, dsr_n_in, cts_n_in};
      chg = {mi[3] ^ mp_r[3], mp_r[2] & ~mi[2], mi[1] ^ mp_r[1], mi[0] ^ mp_r[0]};
      dlt_nxt = chg | (dlt_r & ~{4{rd_msr}});
      rls_p = ier_r[E_RLS] & (oe_r | pe_r | fe_r | bi_r);
      rda_p = ier_r[E_RDA] & rda_lvl;
      // Gate with FIFO mode so a stale timeout never shows after disable
      tmo_p = ier_r[E_RDA] & tmo_r & fen_r;
      thr_p = ier_r[E_THR] & thip_r;
      ms_p = ier_r[E_MS] & (|dlt_r);
      // Fixed priority chain, line status first
      if (rls_p) prio = ID_RLS;
      else if (rda_p) prio = ID_RDA;
      else if (tmo_p) prio = ID_TMO;
      else if (thr_p) prio = ID_THR;
      else if (ms_p) prio = ID_MS;
      else prio = ID_NONE;
      iir_nxt = hold ? iir_r : prio;
      irq_nxt = (prio != ID_NONE) & mcr_r[M_OUT2];
      dtr_n_nxt = mcr_r[M_LOOP] | ~mcr_r[M_DTR];
      rts_n_nxt = mcr_r[M_LOOP] | ~mcr_r[M_RTS];
   end

   // ==========================================================
   // State registers
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ier_r <= 4'h0;
         lcr_r <= REG_RST;
         mcr_r <= 5'h00;
         dll_r <= DLL_RST;
         dlm_r <= REG_RST;
         scr_r <= REG_RST;
         thr_r <= REG_RST;
         fen_r <= 1'b0;
         trg_r <= 2'b00;
         rdata_r <= REG_RST;
         div_cnt_r <= DIV_ONE;
         tick_r <= 1'b0;
         bph_r <= 5'h00;
         tst_r <= TX_IDLE;
         tph_r <= 5'h00;
         tbit_r <= 3'h0;
         tsh_r <= REG_RST;
         tpar_r <= 1'b0;
         txi_r <= 1'b1;
         txd_r <= 1'b1;
         thr_full_r <= 1'b0;
         rst_r <= RX_IDLE;
         rph_r <= 5'h00;
         rbit_r <= 3'h0;
         rsh_r <= REG_RST;
         rpe_r <= 1'b0;
         {oe_r, pe_r, fe_r, bi_r, tmo_r, thip_r} <= 6'h00;
         tcnt_r <= 6'h00;
         mp_r <= 4'h0;
         dlt_r <= 4'h0;
         iir_r <= ID_NONE;
         irq_r <= 1'b0;
         dtr_n_r <= 1'b1;
         rts_n_r <= 1'b1;
      end else begin
         ier_r <= ier_nxt;
         lcr_r <= lcr_nxt;
         mcr_r <= mcr_nxt;
         dll_r <= dll_nxt;
         dlm_r <= dlm_nxt;
         scr_r <= scr_nxt;
         thr_r <= thr_nxt;
         fen_r <= fen_nxt;
         trg_r <= trg_nxt;
         rdata_r <= rdata_nxt;
         div_cnt_r <= div_cnt_nxt;
         tick_r <= tick_nxt;
         bph_r <= bph_nxt;
         tst_r <= tst_nxt;
         tph_r <= tph_nxt;
         tbit_r <= tbit_nxt;
         tsh_r <= tsh_nxt;
         tpar_r <= tpar_nxt;
         txi_r <= txi_nxt;
         txd_r <= txd_nxt;
         thr_full_r <= thr_full_nxt;
         rst_r <= rst_nxt;
         rph_r <= rph_nxt;
         rbit_r <= rbit_nxt;
         rsh_r <= rsh_nxt;
         rpe_r <= rpe_nxt;
         {oe_r, pe_r, fe_r, bi_r, tmo_r, thip_r} <= {oe_nxt, pe_nxt, fe_nxt, bi_nxt, tmo_nxt, thip_nxt};
         tcnt_r <= tcnt_nxt;
         mp_r <= mi;
         dlt_r <= dlt_nxt;
         iir_r <= iir_nxt;
         irq_r <= irq_nxt;
         dtr_n_r <= dtr_n_nxt;
         rts_n_r <= rts_n_nxt;
      end
   end
   assign rdata_out = rdata_r;
   assign txd_out = txd_r;
   assign irq_out = irq_r;
   assign dtr_n_out = dtr_n_r;
   assign rts_n_out = rts_n_r;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   property p_prio_rls;
      rls_p && !hold |=> iir_r == ID_RLS;
   endproperty
   a_prio_rls: assert property (p_prio_rls) else $error("line status not on top");
   property p_prio_rda;
      !rls_p && rda_p && !hold |=> iir_r == ID_RDA;
   endproperty
   a_prio_rda: assert property (p_prio_rda) else $error("data ready rank wrong");
   property p_freeze;
      hold |=> $stable(iir_r);
   endproperty
   a_freeze: assert property (p_freeze) else $error("ident moved during read");
   property p_pend_bit;
      hold |=> rdata_out[0] == ($past(iir_r) == ID_NONE);
   endproperty
   a_pend_bit: assert property (p_pend_bit) else $error("pending bit wrong");
   property p_tmo_fifo;
      !fen_r && !hold ##1 !fen_r |-> !iir_r[3];
   endproperty
   a_tmo_fifo: assert property (p_tmo_fifo) else $error("bit 3 set outside FIFO mode");
   property p_hi_bits;
      hold |=> rdata_out[5:4] == 2'b00 && rdata_out[7:6] == {2{$past(fen_r)}};
   endproperty
   a_hi_bits: assert property (p_hi_bits) else $error("ident bits 7:4 wrong");
   property p_trig;
      host_in.wr && host_in.addr == A_IIR && host_in.wdata[F_EN]
         |=> trg_r == $past(host_in.wdata[F_TRG +: 2]);
   endproperty
   a_trig: assert property (p_trig) else $error("trigger level not taken");
   property p_break;
      lcr_r[L_BRK] && !mcr_r[M_LOOP] |=> !txd_out;
   endproperty
   a_break: assert property (p_break) else $error("break not on line");
   property p_mcr;
      host_in.wr && host_in.addr == A_MCR |=> mcr_r == $past(host_in.wdata[4:0]);
   endproperty
   a_mcr: assert property (p_mcr) else $error("modem control not written");
   property p_lsr_clr;
      rd_lsr && !rx_push |=> !oe_r && !pe_r && !fe_r;
   endproperty
   a_lsr_clr: assert property (p_lsr_clr) else $error("line status not cleared");
   c_rls: cover property (iir_r == ID_RLS && irq_out);
   c_tmo: cover property (iir_r == ID_TMO);
   c_thr: cover property (hold && iir_r == ID_THR);
   c_full: cover property (!q_ready);
endmodule : uic_top
`default_nettype wire

// File: common/uic_pkg.sv
// Register map, field positions, codes and carriers for the serial port core
package uic_pkg;
   // ==========================================================
   // Register offsets (host address bits 2:0)
   localparam logic [2:0] A_DATA = 3'h0;
   localparam logic [2:0] A_IER = 3'h1;
   localparam logic [2:0] A_IIR = 3'h2;
   localparam logic [2:0] A_LCR = 3'h3;
   localparam logic [2:0] A_MCR = 3'h4;
   localparam logic [2:0] A_LSR = 3'h5;
   localparam logic [2:0] A_MSR = 3'h6;
   localparam logic [2:0] A_SCR = 3'h7;
   // ==========================================================
   // Field positions
   localparam int L_STB = 2;
   localparam int L_PEN = 3;
   localparam int L_EPS = 4;
   localparam int L_STK = 5;
   localparam int L_BRK = 6;
   localparam int L_DLS = 7;
   localparam int M_DTR = 0;
   localparam int M_RTS = 1;
   localparam int M_OUT2 = 3;
   localparam int M_LOOP = 4;
   localparam int E_RDA = 0;
   localparam int E_THR = 1;
   localparam int E_RLS = 2;
   localparam int E_MS = 3;
   localparam int F_EN = 0;
   localparam int F_RCLR = 1;
   localparam int F_TRG = 6;
   // ==========================================================
   // Identification codes, bits 3:0
   localparam logic [3:0] ID_NONE = 4'h1;
   localparam logic [3:0] ID_RLS = 4'h6;
   localparam logic [3:0] ID_RDA = 4'h4;
   localparam logic [3:0] ID_TMO = 4'hC;
   localparam logic [3:0] ID_THR = 4'h2;
   localparam logic [3:0] ID_MS = 4'h0;
   // ==========================================================
   // Timing: ticks are 16 per bit time
   localparam logic [4:0] PH_HALF = 5'h07;
   localparam logic [4:0] PH_BIT = 5'h0F;
   localparam logic [4:0] PH_STOP15 = 5'h17;
   localparam logic [4:0] PH_STOP2 = 5'h1F;
   localparam logic [2:0] LEN_BASE = 3'h4;
   localparam logic [3:0] CH_BASE = 4'h7;
   localparam logic [15:0] DIV_ONE = 16'h0001;
   // ==========================================================
   // Receive queue and trigger levels
   localparam int RXQ_DEPTH = 32;
   localparam int RXQ_AW = 5;
   localparam logic [5:0] TRG_1 = 6'h01;
   localparam logic [5:0] TRG_4 = 6'h04;
   localparam logic [5:0] TRG_8 = 6'h08;
   localparam logic [5:0] TRG_14 = 6'h0E;
   // Reset values
   localparam logic [7:0] DLL_RST = 8'h01;
   localparam logic [7:0] REG_RST = 8'h00;
   // ==========================================================
   // Carriers
   typedef struct packed {
      logic rd;
      logic wr;
      logic [2:0] addr;
      logic [7:0] wdata;
   } uic_hreq_type;
   typedef struct packed {
      logic bi;
      logic fe;
      logic pe;
      logic [7:0] data;
   } uic_rxch_type;
endpackage : uic_pkg

// File: dv/uic_peer.sv
// Serial peer model driving the receive line and one modem input
`timescale 1ns/10ps
`default_nettype none
module uic_peer (
   input wire logic clk_in, // Clock
   output logic rxd_out, // Line into the port
   output logic cts_n_out // Clear to send, low
);
   // ==========
   // Line idles at mark so the port sees no false start
   initial begin
      rxd_out = 1'b1;
      cts_n_out = 1'b1;
   end
   // One frame of 16 clocks a bit, LSB first; bad flips parity
   task automatic send(input logic [7:0] d, input logic bad);
      logic [10:0] f;
      f = {1'b1, ^d ^ bad, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         @(negedge clk_in);
         rxd_out = f[i];
         repeat (15) @(negedge clk_in);
      end
   endtask : send
endmodule : uic_peer
`default_nettype wire

// File: dv/testbench.sv
// Register-level testbench for the serial port core
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import uic_pkg::*;
   logic clk_in = 1'b0;
   logic resetn_in = 1'b0;
   uic_hreq_type host = '0;
   logic [7:0] rdata_out;
   logic txd_out, rxd, cts_n, dtr_n_out, rts_n_out, irq_out;
   int miscompares = 0;
   int tests_run = 0;
   int cycles = 0;
   uic_top i_uic_top (.clk_in(clk_in), .resetn_in(resetn_in), .host_in(host),
      .rdata_out(rdata_out), .txd_out(txd_out), .rxd_in(rxd), .cts_n_in(cts_n),
      .dsr_n_in(1'b1), .ri_n_in(1'b1), .dcd_n_in(1'b1), .dtr_n_out(dtr_n_out),
      .rts_n_out(rts_n_out), .irq_out(irq_out));
   uic_peer i_uic_peer (.clk_in(clk_in), .rxd_out(rxd), .cts_n_out(cts_n));
   // ==========
   // Clock; a hang is cut short well past the longest sequence
   initial begin
      forever #25 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      tests_run++;
      if (s !== e) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // Strobes last one cycle; inputs move on the falling edge
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge clk_in);
      host = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(negedge clk_in);
      host = '0;
   endtask : wr
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      @(negedge clk_in);
      host = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(negedge clk_in);
      host = '0;
      chk($sformatf("offset %0d", a), e, rdata_out);
   endtask : rd
   initial begin
      repeat (5) @(negedge clk_in);
      resetn_in = 1'b1;
      rd(A_IIR, 8'h01);
      wr(A_MCR, 8'hFF);
      rd(A_MCR, 8'h1F);
      wr(A_MCR, 8'h0B);
      // Pins are registered from the control register, one cycle behind it
      @(negedge clk_in);
      chk("dtr rts", 8'h00, {6'h00, dtr_n_out, rts_n_out});
      wr(A_LCR, 8'h9B);
      rd(A_IIR, 8'h01);
      wr(A_DATA, 8'h01);
      rd(A_DATA, 8'h01);
      wr(A_LCR, 8'h1B);
      rd(A_LCR, 8'h1B);
      wr(A_IER, 8'h07);
      rd(A_IIR, 8'h02);
      // The interrupt line drops one cycle after the source clears
      @(negedge clk_in);
      chk("irq", 8'h00, {7'h00, irq_out});
      rd(A_IIR, 8'h01);
      // Trigger of four so a lone byte waits for the timeout
      wr(A_IIR, 8'h41);
      rd(A_IIR, 8'hC1);
      i_uic_peer.send(8'h5A, 1'b1);
      repeat (5) @(negedge clk_in);
      rd(A_IIR, 8'hC6);
      rd(A_LSR, 8'hE5);
      rd(A_IIR, 8'hC1);
      repeat (800) @(negedge clk_in);
      rd(A_IIR, 8'hCC);
      rd(A_DATA, 8'h5A);
      rd(A_IIR, 8'hC1);
      for (int i = 1; i < 5; i++) begin
         i_uic_peer.send(8'(i * 17), 1'b0);
      end
      repeat (5) @(negedge clk_in);
      rd(A_IIR, 8'hC4);
      rd(A_DATA, 8'h11);
      rd(A_IIR, 8'hC1);
      wr(A_LCR, 8'h5B);
      repeat (4) @(negedge clk_in);
      chk("txd", 8'h00, {7'h00, txd_out});
      wr(A_LCR, 8'h1B);
      repeat (4) @(negedge clk_in);
      chk("txd", 8'h01, {7'h00, txd_out});
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
